// >>> shared/urt_wdog_map.vh
// Constants for the one-time watchdog: key port, key bytes, counts.
// Assumes inclusion by bare name from the design files.
`ifndef URT_WDOG_MAP_VH
`define URT_WDOG_MAP_VH
`define URT_KEY_PORT_ADDR   8'ha6
`define URT_KEY_FIRST       8'h1e
`define URT_KEY_SECOND      8'he1
`define URT_CNT_WIDTH       14
`define URT_CNT_OVERFLOW    14'h3fff
`define URT_CNT_RESET       14'h0000
`define URT_MC_PERIODS_X2   4'h6
`define URT_MC_PERIODS_X1   4'hc
`define URT_RST_PERIODS_X2  8'h62
`define URT_RST_PERIODS_X1  8'hc4
`endif

// >>> core/urt_cycle_strobe.v
// Machine-cycle strobe divider for the watchdog.
// Assumes clk is the oscillator clock and osc_run gates it logically.
`timescale 1ns/1ps
`default_nettype none
`include "urt_wdog_map.vh"
module urt_cycle_strobe (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Control
  input  wire       osc_run,
  input  wire       six_clk_mode,
  // Strobe
  output reg        mc_tick_ff
);
  reg  [3:0] div_ff;
  wire [3:0] last_cnt = six_clk_mode ? (`URT_MC_PERIODS_X2 - 4'h1)
                                     : (`URT_MC_PERIODS_X1 - 4'h1);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff     <= 4'h0;
      mc_tick_ff <= 1'b0;
    end else if (!osc_run) begin
      mc_tick_ff <= 1'b0;
    end else if (div_ff >= last_cnt) begin
      div_ff     <= 4'h0;
      mc_tick_ff <= 1'b1;
    end else begin
      div_ff     <= div_ff + 4'h1;
      mc_tick_ff <= 1'b0;
    end
  end
endmodule // urt_cycle_strobe
`default_nettype wire

// >>> core/urt_watchdog.v
// One-time enabled upset recovery timer with reset-out pulse.
// Assumes SFR writes arrive as one-cycle strobes on the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "urt_wdog_map.vh"
module urt_watchdog (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Special-function register write port
  input  wire       sfr_wr,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  // Mode and oscillator state
  input  wire       osc_run,
  input  wire       six_clk_mode,
  // Reset pin, drive side
  output reg        rst_pin_out_ff,
  output reg        rst_pin_oe_ff,
  // Internal device reset request and watchdog enable flag
  output reg        dev_reset_ff,
  output reg        wdog_enabled_ff
);
  // ----------------------------------------
  // State encoding
  // ----------------------------------------
  // The pulse phase is a state of its own, so that key writes can never
  // disturb an overflow that is already under way.
  localparam [1:0] ST_OFF   = 2'b00;
  localparam [1:0] ST_ON    = 2'b01;
  localparam [1:0] ST_PULSE = 2'b10;

  // ----------------------------------------
  // Machine-cycle strobe
  // ----------------------------------------
  wire mc_tick;

  urt_cycle_strobe u_strobe (
    .clk          (clk),
    .rst_n        (rst_n),
    .osc_run      (osc_run),
    .six_clk_mode (six_clk_mode),
    .mc_tick_ff   (mc_tick)
  );

  // ----------------------------------------
  // Registers and next values
  // ----------------------------------------
  reg  [1:0]                state_ff;
  reg  [1:0]                nxt_state;
  reg  [`URT_CNT_WIDTH-1:0] count_ff;
  reg  [`URT_CNT_WIDTH-1:0] nxt_count;
  reg                       armed_ff;
  reg                       nxt_armed;
  reg  [7:0]                pulse_ff;
  reg  [7:0]                nxt_pulse;
  reg                       nxt_pin_out;
  reg                       nxt_pin_oe;
  reg                       nxt_dev_reset;
  reg                       nxt_enabled;

  // ----------------------------------------
  // Key port decode
  // ----------------------------------------
  // The key port holds no readable state, so reads need no decode at all.
  wire       key_wr;
  wire       key_first;
  wire       key_pair;
  wire       at_top;
  wire [7:0] pulse_len;

  assign key_wr    = sfr_wr && (sfr_addr == `URT_KEY_PORT_ADDR);
  assign key_first = key_wr && (sfr_wdata == `URT_KEY_FIRST);
  assign key_pair  = key_wr && armed_ff && (sfr_wdata == `URT_KEY_SECOND);
  assign at_top    = (count_ff == `URT_CNT_OVERFLOW);
  assign pulse_len = six_clk_mode ? `URT_RST_PERIODS_X2 : `URT_RST_PERIODS_X1;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always @* begin
    nxt_state     = state_ff;
    nxt_count     = count_ff;
    nxt_armed     = armed_ff;
    nxt_pulse     = pulse_ff;
    nxt_pin_out   = rst_pin_out_ff;
    nxt_pin_oe    = rst_pin_oe_ff;
    nxt_dev_reset = dev_reset_ff;
    nxt_enabled   = wdog_enabled_ff;
    case (state_ff)
      ST_OFF: begin
        // The counter stays frozen here until a full key pair arrives.
        if (key_wr) begin
          nxt_armed = key_first;
        end
        if (key_pair) begin
          nxt_state   = ST_ON;
          nxt_enabled = 1'b1;
          nxt_count   = `URT_CNT_RESET;
        end
      end
      ST_ON: begin
        // No key value leads back to ST_OFF; only overflow or reset do.
        if (at_top) begin
          nxt_state     = ST_PULSE;
          nxt_enabled   = 1'b0;
          nxt_armed     = 1'b0;
          nxt_count     = `URT_CNT_RESET;
          nxt_pulse     = pulse_len - 8'h01;
          nxt_pin_out   = 1'b1;
          nxt_pin_oe    = 1'b1;
          nxt_dev_reset = 1'b1;
        end else begin
          if (key_wr) begin
            nxt_armed = key_first;
          end
          if (key_pair) begin
            nxt_count = `URT_CNT_RESET;
          end else if (mc_tick) begin
            nxt_count = count_ff + 14'h0001;
          end
        end
      end
      ST_PULSE: begin
        // The mode is latched into the length at overflow; a later mode
        // change does not stretch or cut a pulse in flight.
        if (pulse_ff == 8'h00) begin
          nxt_state     = ST_OFF;
          nxt_pin_out   = 1'b0;
          nxt_pin_oe    = 1'b0;
          nxt_dev_reset = 1'b0;
        end else begin
          nxt_pulse = pulse_ff - 8'h01;
        end
      end
      default: begin
        nxt_state     = ST_OFF;
        nxt_enabled   = 1'b0;
        nxt_armed     = 1'b0;
        nxt_count     = `URT_CNT_RESET;
        nxt_pulse     = 8'h00;
        nxt_pin_out   = 1'b0;
        nxt_pin_oe    = 1'b0;
        nxt_dev_reset = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State and key registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff        <= ST_OFF;
      armed_ff        <= 1'b0;
      wdog_enabled_ff <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      armed_ff        <= nxt_armed;
      wdog_enabled_ff <= nxt_enabled;
    end
  end

  // ----------------------------------------
  // Counter register
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= `URT_CNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ----------------------------------------
  // Reset-out pulse registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff       <= 8'h00;
      rst_pin_out_ff <= 1'b0;
      rst_pin_oe_ff  <= 1'b0;
      dev_reset_ff   <= 1'b0;
    end else begin
      pulse_ff       <= nxt_pulse;
      rst_pin_out_ff <= nxt_pin_out;
      rst_pin_oe_ff  <= nxt_pin_oe;
      dev_reset_ff   <= nxt_dev_reset;
    end
  end
endmodule // urt_watchdog
`default_nettype wire

// >>> sim/urt_wdog_chk.sv
// Assertions on the one-time watchdog top-level ports.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module urt_wdog_chk (
  input wire logic       clk, rst_n, sfr_wr, osc_run, six_clk_mode,
  input wire logic [7:0] sfr_addr, sfr_wdata,
  input wire logic       rst_pin_out_ff, rst_pin_oe_ff, dev_reset_ff, wdog_enabled_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_oe_follows_out: assert property (rst_pin_out_ff == rst_pin_oe_ff)
    else $error("pin enable and level differ");
  chk_dev_with_pin: assert property (dev_reset_ff == rst_pin_out_ff)
    else $error("device reset and pin differ");
  chk_enable_by_key: assert property ($rose(wdog_enabled_ff) |->
    $past(sfr_wr && sfr_addr == 8'ha6 && sfr_wdata == 8'he1)) else $error("enable without key");
  chk_stay_enabled: assert property ($fell(wdog_enabled_ff) |-> rst_pin_out_ff)
    else $error("disabled without overflow");
  chk_pulse_short: assert property ($rose(rst_pin_out_ff) && $past(six_clk_mode) |->
    ##97 rst_pin_out_ff ##1 !rst_pin_out_ff) else $error("short pulse length wrong");
  chk_pulse_long: assert property ($rose(rst_pin_out_ff) && !$past(six_clk_mode) |->
    ##195 rst_pin_out_ff ##1 !rst_pin_out_ff) else $error("long pulse length wrong");
  chk_pulse_cause: assert property ($rose(rst_pin_out_ff) |-> $past(wdog_enabled_ff))
    else $error("pulse while disabled");
  chk_idle_quiet: assert property (!wdog_enabled_ff && !rst_pin_out_ff |=> !rst_pin_out_ff)
    else $error("pulse from idle");
  cover property ($rose(wdog_enabled_ff));
  cover property ($rose(rst_pin_oe_ff));
  cover property ($fell(rst_pin_oe_ff));
endmodule // urt_wdog_chk
bind urt_watchdog urt_wdog_chk i_urt_wdog_chk (.clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr),
  .osc_run(osc_run), .six_clk_mode(six_clk_mode), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .rst_pin_out_ff(rst_pin_out_ff), .rst_pin_oe_ff(rst_pin_oe_ff),
  .dev_reset_ff(dev_reset_ff), .wdog_enabled_ff(wdog_enabled_ff));
`default_nettype wire

// >>> sim/tb.sv
// Testbench for the one-time watchdog: key sequences, service, overflow pulse.
// Assumes the design and its key map header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, rst_n, sfr_wr, osc_run, six_clk_mode;
  logic [7:0] sfr_addr, sfr_wdata;
  wire        rst_pin_out_ff, rst_pin_oe_ff, dev_reset_ff, wdog_enabled_ff;
  int         n_mismatch, n_compared, n;
  urt_watchdog i_urt_watchdog (.clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .osc_run(osc_run), .six_clk_mode(six_clk_mode),
    .rst_pin_out_ff(rst_pin_out_ff), .rst_pin_oe_ff(rst_pin_oe_ff),
    .dev_reset_ff(dev_reset_ff), .wdog_enabled_ff(wdog_enabled_ff));
  initial begin clk = 0; forever #25 clk = ~clk; end
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk); sfr_wr = 1; sfr_addr = a; sfr_wdata = d;
    @(negedge clk); sfr_wr = 0;
    @(negedge clk);
  endtask
  task automatic chk(input logic v, e);
    n_compared++;
    if (v !== e) begin n_mismatch++; $display("Error at %0t: got %b", $time, v); end
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The overflow run alone takes about 98,000 clocks, just under 5 ms.
  initial begin #5500000; n_mismatch++; wrap_up; end
  initial begin
    {rst_n, sfr_wr, sfr_addr, sfr_wdata} = 0; osc_run = 1; six_clk_mode = 1;
    repeat (16) @(negedge clk); rst_n = 1;
    chk(wdog_enabled_ff, 0);
    wr(8'ha6, 8'he1); chk(wdog_enabled_ff, 0);
    wr(8'ha6, 8'h1e); wr(8'ha6, 8'h55); wr(8'ha6, 8'he1); chk(wdog_enabled_ff, 0);
    wr(8'ha6, 8'h1e); wr(8'h8e, 8'h00); wr(8'ha6, 8'he1); chk(wdog_enabled_ff, 1);
    wr(8'ha6, 8'h00); wr(8'ha6, 8'h1e); wr(8'ha6, 8'h00); chk(wdog_enabled_ff, 1);
    $display("key tests done");
    rst_n = 0; repeat (4) @(negedge clk); rst_n = 1;
    chk(wdog_enabled_ff, 0);
    six_clk_mode = 0;
    wr(8'ha6, 8'h1e); wr(8'ha6, 8'he1); chk(wdog_enabled_ff, 1);
    repeat (100) @(negedge clk);
    wr(8'ha6, 8'h1e); wr(8'ha6, 8'he1);
    repeat (1200) @(negedge clk);
    osc_run = 0; repeat (200) @(negedge clk); osc_run = 1; six_clk_mode = 1;
    n = 0;
    while (rst_pin_oe_ff !== 1 && n < 100000) begin
      @(negedge clk); n++;
      if (n == 97500) six_clk_mode = 0;
    end
    chk(n inside {[97830:97960]}, 1);
    chk(dev_reset_ff & rst_pin_out_ff, 1);
    chk(wdog_enabled_ff, 0);
    n = 0;
    while (rst_pin_oe_ff === 1 && n < 300) begin @(negedge clk); n++; end
    chk(n == 196, 1);
    repeat (100) @(negedge clk);
    chk(rst_pin_oe_ff | wdog_enabled_ff, 0);
    $display("overflow test done");
    wrap_up;
  end
endmodule // tb
`default_nettype wire
